// [core/ddl_regs.svh]
// ddl constants: frame layout, commands, host register map, link timing
`ifndef DDL_REGS_SVH
`define DDL_REGS_SVH
// Notes on behaviour
// R1 - 24-bit shift register samples on falling edges
// R2 - low frame sync opens 24 sampled clocks
// R3 - output shifts on rising edges, readback or chain
// R4 - load pulse copies new input data
// R5 - load pin pulsed or held low
// R6 - reset acts on falling edge, blocks loads
// R7 - reset loads zero or midscale by select
// R8 - power-up code follows reset select level
// R9 - power-up waits for reset pin release
// R10 - gain pin picks single or double span
// R11 - 830 ns between updating frame sync rises
// R12 - 800 ns from load fall to sync rise
// R13 - serial clock no faster than 50 MHz
// R14 - output released after frame sync rises
// R15 - frame holds command, address, 16-bit data
// =====================================================
// frame layout
`define DDL_FRAME_BITS 24
`define DDL_CODE_BITS 16
`define DDL_CH_A_BIT 0
`define DDL_CH_B_BIT 3
`define DDL_CMD_WR_IN 4'h1
`define DDL_CMD_UPD 4'h2
`define DDL_CMD_WR_UPD 4'h3
`define DDL_CMD_RDBK 4'h9
`define DDL_CODE_ZERO 16'h0000
`define DDL_CODE_MID 16'h8000
// =====================================================
// host register map
`define DDL_OFS_CTRL 12'h000
`define DDL_OFS_TX 12'h004
`define DDL_OFS_RX 12'h008
`define DDL_OFS_STAT 12'h00C
`define DDL_CTRL_GO 0
`define DDL_CTRL_LOAD_DAC_N 1
`define DDL_CTRL_RST 2
`define DDL_CTRL_GAIN 3
`define DDL_CTRL_RSEL 4
`define DDL_CTRL_HOLD 5
// =====================================================
// timing in ns, cycle counts derived from the sys clock
`define DDL_SYS_NS 25
`define DDL_CYC_UP(ns) (((ns) + `DDL_SYS_NS - 1) / `DDL_SYS_NS)
`define DDL_SCLK_MIN_NS 20
`define DDL_T9_NS 830
`define DDL_T11_NS 15
`define DDL_T13_NS 30
`define DDL_T14_NS 800
`define DDL_T15_NS 30
`define DDL_T9_CYC `DDL_CYC_UP(`DDL_T9_NS)
`define DDL_T11_CYC `DDL_CYC_UP(`DDL_T11_NS)
`define DDL_T13_CYC `DDL_CYC_UP(`DDL_T13_NS)
`define DDL_T14_CYC `DDL_CYC_UP(`DDL_T14_NS)
`define DDL_T15_CYC `DDL_CYC_UP(`DDL_T15_NS)
`endif

// [core/ddl_pkg.sv]
// ddl types shared by both ends
`default_nettype none
package ddl_pkg;
	// =====================================================
	// frame and code types
	typedef logic [15:0] ddl_code_t;
	typedef struct packed {
		logic [3:0] cmd; // command field
		logic [3:0] addr; // channel address bits
		ddl_code_t data; // converter code
	} ddl_frame_t;
	// host sequencer states
	typedef enum logic [2:0] {
		DDL_IDLE,
		DDL_LEAD,
		DDL_LOW,
		DDL_HIGH,
		DDL_HOLD
	} ddl_host_st_t;
endpackage
`default_nettype wire

// [core/ddl_link_if.sv]
// ddl serial link between host controller and converter
`timescale 1ns/1ps
`default_nettype none
interface ddl_link_if;
	logic sclk; // serial clock, host made, idles high
	logic sync_n; // frame sync, active low
	logic serial_data_in; // host to device data
	logic serial_data_out; // device data output
	logic sdo_oe; // device drives the output
	logic sdo_seen; // resolved line, pulled high when idle
	logic load_dac_n; // load pin, active low
	logic reset_n; // device reset pin
	logic reset_value_select; // zero or midscale
	logic gain; // span select
	// undriven output line rests high
	assign sdo_seen = sdo_oe ? serial_data_out : 1'b1;
	modport dev (
		input sclk, sync_n, serial_data_in, load_dac_n,
		input reset_n, reset_value_select, gain,
		output serial_data_out, sdo_oe
	);
	modport ctl (
		output sclk, sync_n, serial_data_in, load_dac_n,
		output reset_n, reset_value_select, gain,
		input sdo_seen
	);
endinterface
`default_nettype wire

// [core/ddl_sync2.sv]
// ddl two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ddl_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] sync_q
);
	logic [W-1:0] meta_ff; // first stage, read only by hold_ff
	logic [W-1:0] hold_ff; // second stage
	// =====================================================
	// elaboration check
	if (W < 1) begin : g_chk
		$error("ddl_sync2: width must be positive");
	end
	// both stages, frozen with ce
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else if (ce) begin
			meta_ff <= d;
			hold_ff <= meta_ff;
		end
	end
	assign sync_q = hold_ff;
endmodule
`default_nettype wire

// [core/ddl_device.sv]
// ddl converter end: serial frame capture and dual code registers
`timescale 1ns/1ps
`default_nettype none
`include "ddl_regs.svh"
module ddl_device import ddl_pkg::*; #(
	parameter int CH = 2
) (
	ddl_link_if.dev link,
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	output ddl_code_t dac_code [CH],
	output ddl_code_t in_code [CH],
	output logic span_double
);
	localparam int FB = `DDL_FRAME_BITS;
	localparam logic [4:0] FB5 = 5'(`DDL_FRAME_BITS);
	localparam int ABIT [2] = '{`DDL_CH_A_BIT, `DDL_CH_B_BIT};

	// =====================================================
	// elaboration check
	if (CH < 1 || CH > 2) begin : g_chk
		$error("ddl_device: address field serves one or two channels");
	end

	// =====================================================
	// link domain, clocked by the host's serial clock
	logic [4:0] bit_cnt_ff; // falling edges taken this frame
	logic [FB-1:0] shift_ff; // input shift register
	logic [FB-1:0] word_ff; // last whole frame
	logic done_tgl_ff; // flips once per whole frame
	logic spill_ff; // bit leaving toward the output
	logic sdo_ff; // output pin register
	logic rb_take_ff; // this frame carries readback
	logic [FB-1:0] rb_cap_ff; // readback word for this frame
	logic rb_arm_ff; // sys side: readback requested
	logic [FB-1:0] rb_word_ff; // sys side: readback word

	// bit counter, cleared whenever the frame is closed
	always_ff @(negedge link.sclk or posedge link.sync_n) begin
		if (link.sync_n) begin
			bit_cnt_ff <= '0;
		end else if (bit_cnt_ff != FB5) begin // R2
			bit_cnt_ff <= bit_cnt_ff + 5'd1;
		end
	end

	// shift in on falling edges, extra clocks ignored
	always_ff @(negedge link.sclk) begin
		if (!link.sync_n && bit_cnt_ff != FB5) begin
			shift_ff <= {shift_ff[FB-2:0], link.serial_data_in}; // R1
			// old frame bit or readback bit goes out next
			if (rb_take_ff) begin
				spill_ff <= rb_cap_ff[5'(FB - 1) - bit_cnt_ff]; // R3
			end else begin
				spill_ff <= shift_ff[FB-1]; // R3
			end
		end
	end

	// whole frame: keep the word, flip the toggle
	always_ff @(negedge link.sclk) begin
		if (!link.sync_n && bit_cnt_ff == FB5 - 5'd1) begin
			word_ff <= {shift_ff[FB-2:0], link.serial_data_in}; // R2
		end
	end
	always_ff @(negedge link.sclk or negedge rst_b) begin
		if (!rst_b) begin
			done_tgl_ff <= 1'b0;
		end else if (!link.sync_n && bit_cnt_ff == FB5 - 5'd1) begin
			done_tgl_ff <= ~done_tgl_ff;
		end
	end

	// output changes on rising edges, valid at the falling one
	always_ff @(posedge link.sclk) begin
		sdo_ff <= spill_ff; // R3
	end
	assign link.serial_data_out = sdo_ff;
	// driven only inside a frame, dropped as sync rises
	assign link.sdo_oe = ~link.sync_n; // R14

	// readback word is static while sync is high
	always_ff @(negedge link.sync_n or negedge rst_b) begin
		if (!rst_b) begin
			rb_take_ff <= 1'b0;
			rb_cap_ff <= '0;
		end else begin
			rb_take_ff <= rb_arm_ff;
			rb_cap_ff <= rb_word_ff;
		end
	end

	// =====================================================
	// pin and toggle synchronisers into the sys domain
	logic [4:0] pins_s; // {toggle, reset, load, select, gain}
	logic tgl_s, rstp_s, load_dac_n_s, rsel_s, gain_s;
	logic tgl_d_ff; // last seen toggle
	logic rstp_d_ff; // last seen reset pin
	logic load_dac_n_d_ff; // last seen load pin

	ddl_sync2 #(.W(5)) u_pins (
		.clk(sys_clk),
		.rst_b(rst_b),
		.ce(ce),
		.d({done_tgl_ff, link.reset_n, link.load_dac_n,
			link.reset_value_select, link.gain}),
		.sync_q(pins_s)
	);
	assign {tgl_s, rstp_s, load_dac_n_s, rsel_s, gain_s} = pins_s;

	// delayed copies for edge detection
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tgl_d_ff <= 1'b0;
			rstp_d_ff <= 1'b0;
			load_dac_n_d_ff <= 1'b0;
		end else if (ce) begin
			tgl_d_ff <= tgl_s;
			rstp_d_ff <= rstp_s;
			load_dac_n_d_ff <= load_dac_n_s;
		end
	end

	// =====================================================
	// events and frame decode
	ddl_frame_t frame; // word_ff is stable after the toggle
	logic frame_ev; // one whole frame arrived
	logic rst_fall; // reset pin fell
	logic load_dac_n_fall; // load pulse started
	logic load_dac_n_level; // load pin held low, reset inactive
	logic por_pend_ff; // power-up load still owed
	logic apply_rst; // load reset codes now
	ddl_code_t rst_code; // zero or midscale
	logic span_ff; // span select register

	assign frame = ddl_frame_t'(word_ff); // R15
	assign frame_ev = tgl_s != tgl_d_ff;
	assign rst_fall = rstp_d_ff && !rstp_s; // R6
	// loads ignored while reset pin is low
	assign load_dac_n_fall = load_dac_n_d_ff && !load_dac_n_s && rstp_s; // R6
	assign load_dac_n_level = !load_dac_n_s && rstp_s; // R5
	// power-up completes only once the pin is high
	assign apply_rst = (por_pend_ff && rstp_s) || rst_fall; // R9
	assign rst_code = rsel_s ? `DDL_CODE_MID : `DDL_CODE_ZERO; // R7

	// power-up pending flag
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			por_pend_ff <= 1'b1;
		end else if (ce && rstp_s) begin
			por_pend_ff <= 1'b0; // R8
		end
	end

	// =====================================================
	// per channel input and converter registers
	ddl_code_t in_ff [CH]; // input registers
	ddl_code_t dac_ff [CH]; // converter registers
	logic [CH-1:0] new_ff; // input holds unloaded data

	for (genvar c = 0; c < CH; c++) begin : g_ch
		logic hit; // frame addresses this channel
		logic wr_hit; // frame writes the input register
		logic upd_now; // converter takes the frame data
		logic copy_now; // converter takes the input register
		assign hit = frame_ev && frame.addr[ABIT[c]];
		assign wr_hit = hit && (frame.cmd == `DDL_CMD_WR_IN ||
			frame.cmd == `DDL_CMD_WR_UPD);
		// load pin held low updates as each write lands
		assign upd_now = wr_hit && (frame.cmd == `DDL_CMD_WR_UPD ||
			load_dac_n_level); // R5
		assign copy_now = (hit && frame.cmd == `DDL_CMD_UPD) ||
			(load_dac_n_fall && new_ff[c]); // R4

		// registers of one channel
		always_ff @(posedge sys_clk) begin
			if (!rst_b) begin
				in_ff[c] <= `DDL_CODE_ZERO;
				dac_ff[c] <= `DDL_CODE_ZERO;
				new_ff[c] <= 1'b0;
			end else if (ce) begin
				if (apply_rst) begin
					in_ff[c] <= rst_code; // R7
					dac_ff[c] <= rst_code; // R7
					new_ff[c] <= 1'b0;
				end else begin
					if (wr_hit) begin
						in_ff[c] <= frame.data;
					end
					if (upd_now) begin
						dac_ff[c] <= frame.data;
					end else if (copy_now) begin
						dac_ff[c] <= in_ff[c]; // R4
					end
					// a write with the load pin held low goes straight to the converter, not new
					if (wr_hit && !upd_now) begin
						new_ff[c] <= 1'b1;
					end else if (copy_now || upd_now) begin
						new_ff[c] <= 1'b0;
					end
				end
			end
		end
		assign dac_code[c] = dac_ff[c];
		assign in_code[c] = in_ff[c];
	end

	// =====================================================
	// readback request, served in the next frame
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rb_arm_ff <= 1'b0;
			rb_word_ff <= '0;
		end else if (ce && frame_ev) begin
			rb_arm_ff <= frame.cmd == `DDL_CMD_RDBK; // R3
			// lowest addressed channel answers
			if (frame.addr[ABIT[0]] || CH == 1) begin
				rb_word_ff <= {frame.cmd, frame.addr, in_ff[0]};
			end else begin
				rb_word_ff <= {frame.cmd, frame.addr, in_ff[CH-1]};
			end
		end
	end

	// span select follows the gain pin
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			span_ff <= 1'b0;
		end else if (ce) begin
			span_ff <= gain_s; // R10
		end
	end
	assign span_double = span_ff;
endmodule
`default_nettype wire

// [core/ddl_host.sv]
// ddl host end: APB registers and serial frame sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ddl_regs.svh"
module ddl_host import ddl_pkg::*; #(
	parameter int HALF = 3
) (
	ddl_link_if.ctl link,
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int FB = `DDL_FRAME_BITS;
	// =====================================================
	// elaboration check: sync lag and clock ceiling
	if (HALF < 3 || 2 * HALF * `DDL_SYS_NS < `DDL_SCLK_MIN_NS) begin : g_chk
		$error("ddl_host: HALF too small"); // R13
	end

	ddl_host_st_t st_ff; // sequencer state
	logic [7:0] ph_cnt_ff; // cycles left in a half period
	logic [4:0] bit_cnt_ff; // falling edges made
	logic [7:0] gap_cnt_ff; // cycles left of the gap after the last sync rise
	logic [7:0] ldw_cnt_ff; // cycles left of the gap after the last load fall
	logic [7:0] lo_cnt_ff; // pulse width left
	logic [FB-1:0] tx_ff, rx_ff; // frame out, frame in
	logic gain_ff, rsel_ff, hold_ff; // static pin levels
	logic go_ff, ldreq_ff, rsreq_ff; // pending orders
	logic sclk_ff, sync_n_ff, serial_data_in_ff, load_dac_n_n_ff, rst_n_ff;
	logic sdo_s; // synchronised device output
	logic take_go, take_ld, take_rs, idle;

	ddl_sync2 #(.W(1)) u_sdo (
		.clk(sys_clk),
		.rst_b(rst_b),
		.ce(ce),
		.d(link.sdo_seen),
		.sync_q(sdo_s)
	);

	// =====================================================
	// APB slave, zero wait states
	logic acc, ok;
	assign acc = psel && penable;
	assign ok = paddr == `DDL_OFS_CTRL || paddr == `DDL_OFS_TX ||
		paddr == `DDL_OFS_RX || paddr == `DDL_OFS_STAT;
	assign pready = 1'b1;
	assign pslverr = acc && !ok;
	// read data registered in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			unique case (paddr)
				`DDL_OFS_CTRL: prdata <= {26'd0, hold_ff, rsel_ff, gain_ff, 3'd0};
				`DDL_OFS_TX: prdata <= {8'd0, tx_ff};
				`DDL_OFS_RX: prdata <= {8'd0, rx_ff};
				`DDL_OFS_STAT: prdata <= {28'd0, rsreq_ff, ldreq_ff, go_ff, !idle};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
	// writes, orders set wins over their own take
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tx_ff <= '0;
			{gain_ff, rsel_ff, hold_ff} <= 3'd0;
			{go_ff, ldreq_ff, rsreq_ff} <= 3'd0;
		end else if (ce) begin
			if (acc && pwrite && paddr == `DDL_OFS_TX) begin
				tx_ff <= pwdata[FB-1:0];
			end
			if (acc && pwrite && paddr == `DDL_OFS_CTRL) begin
				gain_ff <= pwdata[`DDL_CTRL_GAIN];
				rsel_ff <= pwdata[`DDL_CTRL_RSEL];
				hold_ff <= pwdata[`DDL_CTRL_HOLD];
			end
			go_ff <= (acc && pwrite && paddr == `DDL_OFS_CTRL &&
				pwdata[`DDL_CTRL_GO]) || (go_ff && !take_go);
			ldreq_ff <= (acc && pwrite && paddr == `DDL_OFS_CTRL &&
				pwdata[`DDL_CTRL_LOAD_DAC_N]) || (ldreq_ff && !take_ld);
			rsreq_ff <= (acc && pwrite && paddr == `DDL_OFS_CTRL &&
				pwdata[`DDL_CTRL_RST]) || (rsreq_ff && !take_rs);
		end
	end

	// =====================================================
	// order arbitration while the link is quiet
	assign idle = st_ff == DDL_IDLE;
	assign take_rs = idle && rsreq_ff && lo_cnt_ff == 8'd0;
	// load pulse keeps its distance from the last sync rise
	assign take_ld = idle && !take_rs && ldreq_ff && !hold_ff &&
		lo_cnt_ff == 8'd0 && gap_cnt_ff <= 8'(`DDL_T9_CYC - `DDL_T13_CYC);
	assign take_go = idle && !take_rs && !take_ld && go_ff &&
		lo_cnt_ff == 8'd0 && rst_n_ff && (load_dac_n_n_ff || hold_ff);

	// load and reset pins, pulse widths and windows
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			load_dac_n_n_ff <= 1'b1;
			rst_n_ff <= 1'b1;
			lo_cnt_ff <= 8'd0;
			ldw_cnt_ff <= 8'd0;
		end else if (ce) begin
			if (take_rs) begin
				rst_n_ff <= 1'b0;
				lo_cnt_ff <= 8'(`DDL_T15_CYC);
			end else if (take_ld) begin
				load_dac_n_n_ff <= 1'b0;
				lo_cnt_ff <= 8'(`DDL_T11_CYC);
				ldw_cnt_ff <= 8'(`DDL_T14_CYC); // R12
			end else begin
				if (lo_cnt_ff > 8'd1) begin
					lo_cnt_ff <= lo_cnt_ff - 8'd1;
				end else begin
					lo_cnt_ff <= 8'd0;
					rst_n_ff <= 1'b1;
					load_dac_n_n_ff <= !hold_ff; // held low in hold mode
				end
				if (ldw_cnt_ff != 8'd0) begin
					ldw_cnt_ff <= ldw_cnt_ff - 8'd1;
				end
			end
		end
	end

	// frame sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_ff <= DDL_IDLE;
			{sclk_ff, sync_n_ff, serial_data_in_ff} <= 3'b110;
			ph_cnt_ff <= 8'd0;
			bit_cnt_ff <= 5'd0;
			gap_cnt_ff <= 8'd0;
			rx_ff <= '0;
		end else if (ce) begin
			if (gap_cnt_ff != 8'd0) begin
				gap_cnt_ff <= gap_cnt_ff - 8'd1;
			end
			unique case (st_ff)
				DDL_IDLE: if (take_go) begin
					sync_n_ff <= 1'b0;
					serial_data_in_ff <= tx_ff[FB-1];
					ph_cnt_ff <= 8'(HALF - 1);
					bit_cnt_ff <= 5'd0;
					st_ff <= DDL_LEAD;
				end
				DDL_LEAD, DDL_HIGH: if (ph_cnt_ff != 8'd0) begin
					ph_cnt_ff <= ph_cnt_ff - 8'd1;
				end else begin
					if (st_ff == DDL_HIGH) begin
						rx_ff <= {rx_ff[FB-2:0], sdo_s};
					end
					if (bit_cnt_ff == 5'(FB)) begin
						st_ff <= DDL_HOLD; // R2
					end else begin
						sclk_ff <= 1'b0;
						bit_cnt_ff <= bit_cnt_ff + 5'd1;
						ph_cnt_ff <= 8'(HALF - 1);
						st_ff <= DDL_LOW;
					end
				end
				DDL_LOW: if (ph_cnt_ff != 8'd0) begin
					ph_cnt_ff <= ph_cnt_ff - 8'd1;
				end else begin
					sclk_ff <= 1'b1;
					if (bit_cnt_ff != 5'(FB)) begin
						serial_data_in_ff <= tx_ff[5'(FB - 1) - bit_cnt_ff];
					end
					ph_cnt_ff <= 8'(HALF - 1);
					st_ff <= DDL_HIGH;
				end
				DDL_HOLD: if (gap_cnt_ff == 8'd0 && ldw_cnt_ff == 8'd0) begin
					sync_n_ff <= 1'b1;
					gap_cnt_ff <= 8'(`DDL_T9_CYC); // R11
					st_ff <= DDL_IDLE;
				end
			endcase
		end
	end

	assign link.sclk = sclk_ff;
	assign link.sync_n = sync_n_ff;
	assign link.serial_data_in = serial_data_in_ff;
	assign link.load_dac_n = load_dac_n_n_ff;
	assign link.reset_n = rst_n_ff;
	assign link.reset_value_select = rsel_ff;
	assign link.gain = gain_ff;
endmodule
`default_nettype wire

// [test/ddl_link_properties.sv]
// ddl link checker: framing and timing seen on the serial wires
`timescale 1ns/1ps
`default_nettype none
`include "ddl_regs.svh"
module ddl_link_properties (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic sdo_oe,
	input wire logic sdo_seen,
	input wire logic load_dac_n,
	input wire logic reset_n
);
	localparam int T9 = `DDL_T9_CYC; // min sync rise spacing
	localparam int T14 = `DDL_T14_CYC; // min load fall to sync rise
	logic [4:0] falls_ff; // sclk falls in frame
	logic [7:0] rgap_ff; // cycles since sync rose
	logic [7:0] lgap_ff; // cycles since load fell
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// =====================================================
	// helper counters
	// count falls, cleared as a frame opens
	always_ff @(posedge sys_clk) begin
		if (!rst_b || $fell(sync_n)) begin
			falls_ff <= 5'h00;
		end else if ($fell(sclk) && falls_ff != 5'h1F) begin
			falls_ff <= falls_ff + 5'h01;
		end
	end
	// gap since the last frame closed, saturating
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rgap_ff <= 8'hFF;
		end else if ($rose(sync_n)) begin
			rgap_ff <= 8'h01;
		end else if (rgap_ff != 8'hFF) begin
			rgap_ff <= rgap_ff + 8'h01;
		end
	end
	// gap since the last load fall, saturating
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			lgap_ff <= 8'hFF;
		end else if ($fell(load_dac_n)) begin
			lgap_ff <= 8'h01;
		end else if (lgap_ff != 8'hFF) begin
			lgap_ff <= lgap_ff + 8'h01;
		end
	end
	// =====================================================
	// sequences
	sequence s_lead;
		sclk [*3] ##1 !sclk;
	endsequence
	sequence s_rst_pulse;
		!reset_n ##1 reset_n;
	endsequence
	// =====================================================
	// properties
	property p_release;
		sync_n |-> !sdo_oe && sdo_seen;
	endproperty
	a_release: assert property (p_release) else $error("sdo driven outside frame");
	property p_sclk_idle;
		sync_n |-> sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves outside frame");
	property p_frame_len;
		$rose(sync_n) |-> falls_ff == 5'h18;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not 24 falls");
	property p_lead;
		$fell(sync_n) |-> s_lead;
	endproperty
	a_lead: assert property (p_lead) else $error("first sclk fall misplaced");
	property p_sync_gap;
		$rose(sync_n) |-> rgap_ff >= T9;
	endproperty
	a_sync_gap: assert property (p_sync_gap) else $error("sync rises too close");
	property p_load_gap;
		$rose(sync_n) |-> lgap_ff >= T14;
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("sync rise too soon after load");
	property p_sdo_rise;
		!sync_n && $changed(serial_data_out) |-> $rose(sclk);
	endproperty
	a_sdo_rise: assert property (p_sdo_rise) else $error("sdo moved off sclk rise");
	property p_serial_data_in_hold;
		$fell(sclk) |-> $stable(serial_data_in);
	endproperty
	a_serial_data_in_hold: assert property (p_serial_data_in_hold) else $error("data moved at sampling fall");
	property p_rst_pulse;
		$fell(reset_n) |=> s_rst_pulse;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse wrong length");
endmodule
`default_nettype wire

// [test/dual_dac_serial_load_control_tb_top.sv]
// ddl bench: host and converter ends joined, run through the APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ddl_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module dual_dac_serial_load_control_tb_top import ddl_pkg::*; ;
	logic sys_clk; // 40 MHz clock
	logic rst_b; // reset, active low, sync in sys flops, async in link flops
	logic [11:0] paddr; // apb address
	logic psel, penable, pwrite; // apb controls
	logic [31:0] pwdata, prdata; // apb data
	logic pready, pslverr; // apb answer
	ddl_code_t dac_code [2]; // converter registers
	ddl_code_t in_code [2]; // input registers
	logic span_double; // span at the device
	int n_mismatch, checks, cyc; // report counters
	logic [31:0] lvl; // level bits of control
	logic [23:0] mon_in, mon_out; // words seen on the wire
	int mon_n; // sclk falls in frame
	localparam logic [3:0] CH_A = 4'h1 << `DDL_CH_A_BIT; // channel a address
	localparam logic [3:0] CH_B = 4'h1 << `DDL_CH_B_BIT; // channel b address
	// =====================================================
	// the two ends and the checker
	ddl_link_if ddl_link_if_i ();
	ddl_host #(.HALF(3)) ddl_host_i (.link(ddl_link_if_i), .sys_clk(sys_clk), .rst_b(rst_b),
		.ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	ddl_device #(.CH(2)) ddl_device_i (.link(ddl_link_if_i), .sys_clk(sys_clk), .rst_b(rst_b),
		.ce(1'b1), .dac_code(dac_code), .in_code(in_code), .span_double(span_double));
	ddl_link_properties ddl_link_properties_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.sclk(ddl_link_if_i.sclk), .sync_n(ddl_link_if_i.sync_n),
		.serial_data_in(ddl_link_if_i.serial_data_in),
		.serial_data_out(ddl_link_if_i.serial_data_out), .sdo_oe(ddl_link_if_i.sdo_oe),
		.sdo_seen(ddl_link_if_i.sdo_seen), .load_dac_n(ddl_link_if_i.load_dac_n),
		.reset_n(ddl_link_if_i.reset_n));
	// =====================================================
	// wire monitor: input taken at sclk falls, output one fall later
	always @(negedge ddl_link_if_i.sync_n) mon_n = 0;
	always @(negedge ddl_link_if_i.sclk) begin
		if (!ddl_link_if_i.sync_n) begin
			mon_in = {mon_in[22:0], ddl_link_if_i.serial_data_in};
			// bit put out at the previous rise, none before the first fall
			if (mon_n > 0) begin
				mon_out = {mon_out[22:0], ddl_link_if_i.serial_data_out};
			end
			mon_n++;
		end
	end
	// last output bit of a frame comes after the 24th rise
	always @(posedge ddl_link_if_i.sync_n) begin
		mon_out = {mon_out[22:0], ddl_link_if_i.serial_data_out};
	end
	// =====================================================
	// bus and frame tasks
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(a, 1'b1, d, rd, err);
	endtask
	// poll status until nothing is pending, then let the crossing settle
	task automatic idle();
		logic [31:0] st;
		logic err;
		st = 32'h0000_000F;
		for (int i = 0; i < 400 && st[3:0] !== 4'h0; i++) begin
			apb(`DDL_OFS_STAT, 1'b0, 32'h0000_0000, st, err);
		end
		`CHK(st[3:0], 4'h0)
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic frame(input logic [3:0] c, input logic [3:0] a, input ddl_code_t d);
		wr(`DDL_OFS_TX, {8'h00, c, a, d});
		wr(`DDL_OFS_CTRL, lvl | 32'h0000_0001);
		idle();
		`CHK(mon_n, 24)
		`CHK(mon_in, {c, a, d})
		`CHK(ddl_link_if_i.sdo_seen, 1'b1)
	endtask
	task automatic pulse(input int b);
		wr(`DDL_OFS_CTRL, lvl | (32'h0000_0001 << b));
		idle();
	endtask
	// =====================================================
	// scenarios
	task automatic t_reset();
		`CHK({dac_code[0], dac_code[1]}, 32'h0000_0000)
		for (int s = 1; s >= 0; s--) begin
			frame(`DDL_CMD_WR_UPD, CH_A | CH_B, 16'h1234);
			lvl[`DDL_CTRL_RSEL] = s[0];
			wr(`DDL_OFS_CTRL, lvl);
			pulse(`DDL_CTRL_RST);
			for (int i = 0; i < 2; i++) begin
				`CHK(in_code[i], s ? `DDL_CODE_MID : `DDL_CODE_ZERO)
				`CHK(dac_code[i], s ? `DDL_CODE_MID : `DDL_CODE_ZERO)
			end
		end
	endtask
	task automatic t_load();
		frame(`DDL_CMD_WR_IN, CH_A | CH_B, 16'hA5C3);
		`CHK({in_code[0], in_code[1]}, 32'hA5C3_A5C3)
		`CHK({dac_code[0], dac_code[1]}, 32'h0000_0000)
		pulse(`DDL_CTRL_LOAD_DAC_N);
		`CHK({dac_code[0], dac_code[1]}, 32'hA5C3_A5C3)
		frame(`DDL_CMD_WR_IN, CH_B, 16'h0F0F);
		pulse(`DDL_CTRL_LOAD_DAC_N);
		`CHK({dac_code[0], dac_code[1]}, 32'hA5C3_0F0F)
	endtask
	task automatic t_cmds();
		frame(`DDL_CMD_WR_IN, CH_A, 16'h7E81);
		`CHK(dac_code[0], 16'hA5C3)
		frame(`DDL_CMD_UPD, CH_A, 16'h0000);
		`CHK(dac_code[0], 16'h7E81)
		frame(`DDL_CMD_WR_UPD, CH_B, 16'h0001);
		`CHK({in_code[1], dac_code[1]}, 32'h0001_0001)
	endtask
	task automatic t_chain();
		logic [31:0] rd;
		logic err;
		frame(`DDL_CMD_WR_IN, CH_B, 16'h1357);
		frame(`DDL_CMD_WR_IN, CH_B, 16'h2468);
		`CHK(mon_out, {`DDL_CMD_WR_IN, CH_B, 16'h1357})
		apb(`DDL_OFS_RX, 1'b0, 32'h0000_0000, rd, err);
		`CHK(rd, {8'h00, `DDL_CMD_WR_IN, CH_B, 16'h1357})
		frame(`DDL_CMD_RDBK, CH_A, 16'h0000);
		frame(`DDL_CMD_WR_IN, CH_B, 16'h2468);
		`CHK(mon_out[15:0], 16'h7E81)
	endtask
	task automatic t_hold();
		lvl[`DDL_CTRL_HOLD] = 1'b1;
		wr(`DDL_OFS_CTRL, lvl);
		frame(`DDL_CMD_WR_IN, CH_A, 16'h4321);
		`CHK(ddl_link_if_i.load_dac_n, 1'b0)
		`CHK(dac_code[0], 16'h4321)
		lvl[`DDL_CTRL_HOLD] = 1'b0;
		wr(`DDL_OFS_CTRL, lvl);
	endtask
	task automatic t_gain();
		for (int g = 1; g >= 0; g--) begin
			lvl[`DDL_CTRL_GAIN] = g[0];
			wr(`DDL_OFS_CTRL, lvl);
			idle();
			`CHK(span_double, g[0])
		end
	endtask
	task automatic t_bus();
		logic [31:0] rd;
		logic err;
		apb(12'h010, 1'b0, 32'h0000_0000, rd, err);
		`CHK({err, rd}, 33'h1_0000_0000)
	endtask
	// =====================================================
	// verdict, clock, timeout and main sequence
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		// non-blocking so the link flops with async reset see the fall
		rst_b <= 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		lvl = 32'h0000_0000;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_bus();
		t_reset();
		t_load();
		t_cmds();
		t_chain();
		t_hold();
		t_gain();
		give_verdict();
	end
endmodule
`default_nettype wire
